// [adfg_defs.svh]
`ifndef ADFG_DEFS_SVH
`define ADFG_DEFS_SVH
// register addresses within the audio control page
`define ADFG_PAGE_AUDIO 4'h2
`define ADFG_ADDR_FORMAT 6'h00
`define ADFG_ADDR_RSVD 6'h01
`define ADFG_ADDR_GAIN 6'h02
`define ADFG_ADDR_STEP 6'h03
// command word fields
`define ADFG_CMD_RW_BIT 15
`define ADFG_CMD_PG_HI 14
`define ADFG_CMD_PG_LO 11
`define ADFG_CMD_AD_HI 10
`define ADFG_CMD_AD_LO 5
// field positions
`define ADFG_IN_HI 13
`define ADFG_IN_LO 12
`define ADFG_WL_HI 11
`define ADFG_WL_LO 10
`define ADFG_FF_HI 9
`define ADFG_FF_LO 8
`define ADFG_RD_HI 5
`define ADFG_RD_LO 3
`define ADFG_LMUTE_BIT 15
`define ADFG_LVOL_HI 14
`define ADFG_LVOL_LO 8
`define ADFG_RMUTE_BIT 7
`define ADFG_RVOL_HI 6
`define ADFG_RVOL_LO 0
`define ADFG_STEP_LFLAG_BIT 3
`define ADFG_STEP_RFLAG_BIT 2
`define ADFG_STEP_RATE_BIT 1
// reset values and the fixed reserved readback
`define ADFG_FORMAT_RST 16'h0000
`define ADFG_GAIN_RST 16'hFFFF
`define ADFG_RSVD_VAL 16'hFFFF
`define ADFG_VOL_MAX 7'h7F
`endif

// [adfg_pkg.sv]
package adfg_pkg;
	typedef enum logic [1:0] {ADFG_IN_MIC, ADFG_IN_AUX, ADFG_IN_DIFF_A, ADFG_IN_DIFF_B}
		adfg_input_type;
	typedef enum logic [1:0] {ADFG_W16, ADFG_W20, ADFG_W24, ADFG_W32} adfg_width_type;
	typedef enum logic [1:0] {ADFG_FMT_I2S, ADFG_FMT_DSP, ADFG_FMT_RJ, ADFG_FMT_LJ}
		adfg_format_type;
	typedef struct packed {
		logic [1:0] input_select;
		logic [1:0] sample_width_sel;
		logic [1:0] frame_format_sel;
		logic [2:0] playback_rate_div;
	} adfg_format_cfg_type;
	typedef struct packed {
		logic left_mute;
		logic [6:0] left_volume;
		logic right_mute;
		logic [6:0] right_volume;
	} adfg_gain_type;
	typedef enum logic [1:0] {ADFG_CMD, ADFG_DATA, ADFG_DONE} adfg_state_type;
endpackage

// [adfg_regs.sv]
`timescale 1ns/1ps
`include "adfg_defs.svh"
module adfg_regs import adfg_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ctl_sel_n,
	input wire logic ctl_word_valid,
	input wire logic [15:0] ctl_word,
	output logic [15:0] ctl_rdata,
	output logic ctl_rdata_valid,
	input wire logic frame_tick,
	output adfg_format_cfg_type format_cfg,
	output adfg_gain_type gain_cfg,
	output logic [6:0] left_applied,
	output logic [6:0] right_applied,
	output logic left_at_target,
	output logic right_at_target
);
	// host access sequencing
	adfg_state_type state_q;
	logic is_read_q;
	logic [3:0] page_q;
	logic [5:0] addr_q;
	logic hit_audio;
	logic wr_en;
	logic wr_format;
	logic wr_gain;
	logic wr_step;
	logic rd_en;
	logic [15:0] rd_mux;
	// stored settings
	logic [15:0] format_q;
	adfg_gain_type gain_q;
	logic step_rate_q;
	adfg_format_cfg_type format_live_q;
	// soft-step state, index 0 is left and 1 is right
	logic half_q;
	logic step_en;
	logic [6:0] vol_target [2];
	logic [6:0] vol_q [2];
	logic [1:0] at_target;

	// command word then one data word per access; deselect restarts
	always_ff @(posedge clk) begin
		if (rst || ctl_sel_n) begin
			state_q <= ADFG_CMD;
			is_read_q <= 1'b0;
			page_q <= 4'h0;
			addr_q <= 6'h00;
		end else if (ctl_word_valid) begin
			case (state_q)
				ADFG_CMD: begin
					is_read_q <= ctl_word[`ADFG_CMD_RW_BIT];
					page_q <= ctl_word[`ADFG_CMD_PG_HI:`ADFG_CMD_PG_LO];
					addr_q <= ctl_word[`ADFG_CMD_AD_HI:`ADFG_CMD_AD_LO];
					state_q <= ADFG_DATA;
				end
				ADFG_DATA: begin
					state_q <= ADFG_DONE;
				end
				// words after the data word are dropped until deselect
				ADFG_DONE: begin
					state_q <= ADFG_DONE;
				end
				default: begin
					state_q <= ADFG_CMD;
				end
			endcase
		end
	end

	assign hit_audio = (page_q == `ADFG_PAGE_AUDIO);
	// a write lands with the data word; the command word only sets up the access
	assign wr_en = ctl_word_valid && !ctl_sel_n && (state_q == ADFG_DATA) && !is_read_q
		&& hit_audio;
	assign wr_format = wr_en && (addr_q == `ADFG_ADDR_FORMAT);
	assign wr_gain = wr_en && (addr_q == `ADFG_ADDR_GAIN);
	assign wr_step = wr_en && (addr_q == `ADFG_ADDR_STEP);
	// reads of the reserved word and of other pages never change state
	assign rd_en = ctl_word_valid && !ctl_sel_n && (state_q == ADFG_DATA) && is_read_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			format_q <= `ADFG_FORMAT_RST;
		end else if (wr_format) begin
			// reserved bits kept zero so readback cannot mislead
			format_q <= `ADFG_FORMAT_RST;
			format_q[`ADFG_IN_HI:`ADFG_IN_LO] <= ctl_word[`ADFG_IN_HI:`ADFG_IN_LO];
			format_q[`ADFG_WL_HI:`ADFG_WL_LO] <= ctl_word[`ADFG_WL_HI:`ADFG_WL_LO];
			format_q[`ADFG_FF_HI:`ADFG_FF_LO] <= ctl_word[`ADFG_FF_HI:`ADFG_FF_LO];
			format_q[`ADFG_RD_HI:`ADFG_RD_LO] <= ctl_word[`ADFG_RD_HI:`ADFG_RD_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// both channels start muted at full attenuation, so power-up is silent
			gain_q <= `ADFG_GAIN_RST;
		end else if (wr_gain) begin
			gain_q.left_mute <= ctl_word[`ADFG_LMUTE_BIT];
			gain_q.left_volume <= ctl_word[`ADFG_LVOL_HI:`ADFG_LVOL_LO];
			gain_q.right_mute <= ctl_word[`ADFG_RMUTE_BIT];
			gain_q.right_volume <= ctl_word[`ADFG_RVOL_HI:`ADFG_RVOL_LO];
		end
	end

	// only the rate bit is writable; the flag bits are read back live
	always_ff @(posedge clk) begin
		if (rst) begin
			step_rate_q <= 1'b0;
		end else if (wr_step) begin
			step_rate_q <= ctl_word[`ADFG_STEP_RATE_BIT];
		end
	end

	// live copy follows the register only on frame_tick and holds between frames
	always_ff @(posedge clk) begin
		if (rst) begin
			// live copy resets with the register so the two agree until the first write
			format_live_q <= '0;
		end else if (frame_tick) begin
			format_live_q.input_select <= format_q[`ADFG_IN_HI:`ADFG_IN_LO];
			format_live_q.sample_width_sel <= format_q[`ADFG_WL_HI:`ADFG_WL_LO];
			format_live_q.frame_format_sel <= format_q[`ADFG_FF_HI:`ADFG_FF_LO];
			format_live_q.playback_rate_div <= format_q[`ADFG_RD_HI:`ADFG_RD_LO];
		end
	end

	assign format_cfg = format_live_q;
	assign gain_cfg = gain_q;

	// one shared phase so both channels step on the same frames
	always_ff @(posedge clk) begin
		if (rst) begin
			half_q <= 1'b0;
		end else if (frame_tick) begin
			half_q <= ~half_q;
		end
	end
	// slow rate steps on every other frame only
	assign step_en = frame_tick && (!step_rate_q || half_q);
	assign vol_target[0] = gain_q.left_volume;
	assign vol_target[1] = gain_q.right_volume;

	// one code per step is half a decibel, small enough not to click
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		always_ff @(posedge clk) begin
			if (rst) begin
				vol_q[ch] <= `ADFG_VOL_MAX;
			end else if (step_en) begin
				if (vol_q[ch] < vol_target[ch]) begin
					vol_q[ch] <= vol_q[ch] + 7'h01;
				end else if (vol_q[ch] > vol_target[ch]) begin
					vol_q[ch] <= vol_q[ch] - 7'h01;
				end
			end
		end

		assign at_target[ch] = (vol_q[ch] == vol_target[ch]);
	end

	assign left_applied = vol_q[0];
	assign right_applied = vol_q[1];
	// flags compare against the setting, so a write that changes a channel's setting clears that channel's flag at once
	assign left_at_target = at_target[0];
	assign right_at_target = at_target[1];

	always_comb begin
		rd_mux = 16'h0000;
		case (addr_q)
			`ADFG_ADDR_FORMAT: begin
				rd_mux = format_q;
			end
			`ADFG_ADDR_RSVD: begin
				rd_mux = `ADFG_RSVD_VAL;
			end
			`ADFG_ADDR_GAIN: begin
				rd_mux = gain_q;
			end
			`ADFG_ADDR_STEP: begin
				rd_mux[`ADFG_STEP_LFLAG_BIT] = left_at_target;
				rd_mux[`ADFG_STEP_RFLAG_BIT] = right_at_target;
				rd_mux[`ADFG_STEP_RATE_BIT] = step_rate_q;
			end
			// unmapped audio addresses read zero
			default: rd_mux = 16'h0000;
		endcase
		// other pages belong to blocks outside this one and read all ones
		if (!hit_audio) begin
			rd_mux = `ADFG_RSVD_VAL;
		end
	end

	// read data is latched on the data word and presented the cycle after it
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_rdata <= 16'h0000;
			ctl_rdata_valid <= 1'b0;
		end else begin
			// valid is a one-cycle pulse right after the data word
			ctl_rdata_valid <= 1'b0;
			// rdata holds until the next read, so a slow host can still fetch it
			if (rd_en) begin
				ctl_rdata <= rd_mux;
				ctl_rdata_valid <= 1'b1;
			end
		end
	end
endmodule

// [adfg_regs_properties.sv]
`timescale 1ns/1ps
module adfg_checker import adfg_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ctl_sel_n,
	input wire logic ctl_word_valid,
	input wire logic ctl_rdata_valid,
	input wire logic frame_tick,
	input wire adfg_format_cfg_type format_cfg,
	input wire adfg_gain_type gain_cfg,
	input wire logic [6:0] left_applied,
	input wire logic [6:0] right_applied,
	input wire logic left_at_target,
	input wire logic right_at_target
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	format_hold_a: assert property (!frame_tick |=> $stable(format_cfg))
		else $error("format changed between frames");
	left_flag_a: assert property (
		left_at_target == (left_applied == gain_cfg.left_volume)) else $error("left flag");
	right_flag_a: assert property (
		right_at_target == (right_applied == gain_cfg.right_volume)) else $error("right flag");
	left_hold_a: assert property (!frame_tick |=> $stable(left_applied))
		else $error("left gain moved between frames");
	right_hold_a: assert property (!frame_tick |=> $stable(right_applied))
		else $error("right gain moved between frames");
	left_step_a: assert property ($changed(left_applied) |->
		left_applied - $past(left_applied) inside {7'h01, 7'h7F}) else $error("left step");
	right_step_a: assert property ($changed(right_applied) |->
		right_applied - $past(right_applied) inside {7'h01, 7'h7F}) else $error("right step");
	rdata_pulse_a: assert property (ctl_rdata_valid |=> !ctl_rdata_valid)
		else $error("read valid longer than one cycle");
	rdata_source_a: assert property (ctl_rdata_valid |->
		$past(ctl_word_valid && !ctl_sel_n)) else $error("read valid without a word");
	gain_write_a: assert property ($changed(gain_cfg) |->
		$past(ctl_word_valid && !ctl_sel_n)) else $error("gain changed without a write");
endmodule

// [adfg_host_model.sv]
`timescale 1ns/1ps
module adfg_host_model (
	input wire logic clk,
	output logic ctl_sel_n,
	output logic ctl_word_valid,
	output logic [15:0] ctl_word
);
	initial begin
		ctl_sel_n = 1'h1;
		ctl_word_valid = 1'h0;
		ctl_word = 16'h0000;
	end
	task automatic xfer(input logic [15:0] c, input logic [15:0] d);
		@(negedge clk);
		ctl_sel_n = 1'h0;
		ctl_word_valid = 1'h1;
		ctl_word = c;
		@(negedge clk);
		ctl_word = d;
		@(negedge clk);
		ctl_sel_n = 1'h1;
		ctl_word_valid = 1'h0;
		// inverse on release so stale data cannot pass
		ctl_word = ~d;
	endtask
endmodule

// [test_audio_dac_format_gain_regs.sv]
`timescale 1ns/1ps
`include "adfg_defs.svh"
module test_audio_dac_format_gain_regs import adfg_pkg::*; ();
	logic clk, rst, frame_tick, ctl_sel_n, ctl_word_valid, ctl_rdata_valid, lt, rt;
	logic [15:0] ctl_word, ctl_rdata;
	logic [6:0] la, ra;
	adfg_format_cfg_type fc;
	adfg_gain_type gc;
	int bad_count = 0;
	int samples_checked = 0;
	adfg_regs uut (.clk(clk), .rst(rst), .ctl_sel_n(ctl_sel_n), .ctl_word_valid(ctl_word_valid),
		.ctl_word(ctl_word), .ctl_rdata(ctl_rdata), .ctl_rdata_valid(ctl_rdata_valid),
		.frame_tick(frame_tick), .format_cfg(fc), .gain_cfg(gc), .left_applied(la),
		.right_applied(ra), .left_at_target(lt), .right_at_target(rt));
	adfg_host_model host (.clk(clk), .ctl_sel_n(ctl_sel_n), .ctl_word_valid(ctl_word_valid),
		.ctl_word(ctl_word));
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task test_done;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task rd(input logic [3:0] p, input logic [5:0] a, input logic [15:0] e);
		int i;
		host.xfer({1'h1, p, a, 5'h00}, 16'h0000);
		for (i = 0; i < 4 && ctl_rdata_valid !== 1'h1; i++) @(negedge clk);
		if (i == 4) begin
			bad_count++;
			test_done;
		end
		chk("rdata", e, ctl_rdata);
	endtask
	// frame pulses stand for a reference rate inside the legal band
	task tick;
		@(negedge clk) frame_tick = 1'h1;
		@(negedge clk) frame_tick = 1'h0;
	endtask
	task t_fmt;
		logic [15:0] d;
		logic [8:0] p;
		p = 9'h000;
		for (int i = 0; i < 8; i++) begin
			// reserved bits zero; right-justified never meets the 5.5 divisor
			d = {2'h0, i[1:0], i[1:0], ~i[1:0], 2'h0, i[2:0], 3'h0};
			host.xfer({1'h0, `ADFG_PAGE_AUDIO, `ADFG_ADDR_FORMAT, 5'h00}, d);
			chk("hold", {7'h00, p}, {7'h00, fc});
			tick;
			p = {i[1:0], i[1:0], ~i[1:0], i[2:0]};
			chk("cfg", {7'h00, p}, {7'h00, fc});
			rd(`ADFG_PAGE_AUDIO, `ADFG_ADDR_FORMAT, d);
		end
	endtask
	task t_gain;
		host.xfer({1'h0, `ADFG_PAGE_AUDIO, `ADFG_ADDR_GAIN, 5'h00}, 16'h7D7E);
		rd(`ADFG_PAGE_AUDIO, `ADFG_ADDR_GAIN, 16'h7D7E);
		chk("flags", 16'h0000, {14'h0, lt, rt});
		tick;
		chk("app", 16'h7E7E, {1'h0, la, 1'h0, ra});
		chk("flags", 16'h0001, {14'h0, lt, rt});
		tick;
		chk("app", 16'h7D7E, {1'h0, la, 1'h0, ra});
		chk("flags", 16'h0003, {14'h0, lt, rt});
	endtask
	// slow stepping: one code per two frames, whatever the phase
	task t_step;
		host.xfer({1'h0, `ADFG_PAGE_AUDIO, `ADFG_ADDR_STEP, 5'h00}, 16'h0002);
		rd(`ADFG_PAGE_AUDIO, `ADFG_ADDR_STEP, 16'h000E);
		host.xfer({1'h0, `ADFG_PAGE_AUDIO, `ADFG_ADDR_GAIN, 5'h00}, 16'h7B7E);
		chk("gcfg", 16'h7B7E, gc);
		host.xfer({1'h0, 4'h1, `ADFG_ADDR_GAIN, 5'h00}, 16'h0000);
		chk("gpage", 16'h7B7E, gc);
		rd(4'h1, `ADFG_ADDR_GAIN, 16'hFFFF);
		repeat (2) tick;
		chk("slow", 16'h7C7E, {1'h0, la, 1'h0, ra});
		repeat (2) tick;
		chk("slow", 16'h7B7E, {1'h0, la, 1'h0, ra});
		chk("flags", 16'h0003, {14'h0, lt, rt});
	endtask
	task t_reset;
		@(negedge clk) rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		chk("fmt_rst", 16'h0000, {7'h00, fc});
		chk("gain_rst", `ADFG_GAIN_RST, gc);
		chk("app_rst", 16'h7F7F, {1'h0, la, 1'h0, ra});
		chk("flags_rst", 16'h0003, {14'h0, lt, rt});
		rd(`ADFG_PAGE_AUDIO, `ADFG_ADDR_STEP, 16'h000C);
	endtask
	initial begin
		rst = 1'h1;
		frame_tick = 1'h0;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		chk("fmt0", 16'h0000, {7'h00, fc});
		chk("gain0", `ADFG_GAIN_RST, gc);
		rd(`ADFG_PAGE_AUDIO, `ADFG_ADDR_RSVD, `ADFG_RSVD_VAL);
		t_fmt;
		t_gain;
		t_step;
		t_reset;
		test_done;
	end
endmodule
bind adfg_regs adfg_checker chk_i (.clk(clk), .rst(rst), .ctl_sel_n(ctl_sel_n),
	.ctl_word_valid(ctl_word_valid), .ctl_rdata_valid(ctl_rdata_valid), .frame_tick(frame_tick),
	.format_cfg(format_cfg), .gain_cfg(gain_cfg), .left_applied(left_applied),
	.right_applied(right_applied), .left_at_target(left_at_target), .right_at_target(right_at_target));
